// ### design/sfp_codec_end.sv
`timescale 1ns/10ps
// Functional notes
// - encoder sample: 13 bits, left-justified
// - decoder sample left-justified, low three bits zero
// - frame opens with two 6-bit area codes
// - next two area codes are 5 bits
// - next two area codes are 4 bits
// - last two area codes are 3 bits
// - subframe: 7-bit lag, 2-bit gain, 2-bit grid
// - 6-bit block amplitude follows grid code
// - subframe ends with thirteen 3-bit pulse codes
// - any lag 0..127 handled, clamped to 40..120
// - every exchanged word is 16 bits
// - 76 words per 20 ms frame
// - samples run at 8 kHz, 160 per frame
module sfp_codec_end
  import sfp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // link
  sfp_link_if.dev link,
  // samples to the encoder core
  output logic [12:0] encSample,
  output logic encSampleValid,
  output logic encSampleFirst,
  // parameters from the encoder core
  input wire logic [6:0] paramCode,
  input wire logic paramValid,
  output logic paramReady,
  // parameters to the decoder core
  output logic [6:0] decCode,
  output logic [6:0] decCodeIdx,
  output logic decCodeValid,
  output logic decFrameStart,
  output logic [6:0] decodedLag,
  output logic decLagValid,
  output logic lagOutOfRange,
  // samples from the decoder core
  input wire logic signed [17:0] decSampleIn,
  input wire logic decSampleInValid,
  output logic decSampleReady,
  output logic decSampleSat
);
  import sfp_pkg::*;

  typedef struct packed {
    logic encInReady;
    logic [12:0] encSample;
    logic encSampleValid;
    logic encSampleFirst;
    logic [7:0] encSampleCnt;
    sfp_frame_t encState;
    logic [6:0] encIdx;
    logic [1:0][16:0] fifo;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
    logic paramReady;
    logic encOutValid;
    logic [15:0] encOutData;
    logic encOutFirst;
    logic decInReady;
    logic [6:0] decIdx;
    logic [6:0] decCode;
    logic [6:0] decCodeIdx;
    logic decCodeValid;
    logic decFrameStart;
    logic [6:0] decodedLag;
    logic decLagValid;
    logic lagOutOfRange;
    logic decSampleReady;
    logic decOutValid;
    logic [15:0] decOutData;
    logic decSampleSat;
  } sfp_dev_t;

  sfp_dev_t st;
  sfp_dev_t next_st;
  logic push;
  logic pop;
  logic [6:0] rxAt;
  logic [6:0] rxCode;
  logic [15:0] satWord;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.encSampleValid = 1'b0;
    next_st.encSampleFirst = 1'b0;
    next_st.decCodeValid = 1'b0;
    next_st.decFrameStart = 1'b0;
    next_st.decLagValid = 1'b0;
    next_st.lagOutOfRange = 1'b0;
    next_st.decSampleSat = 1'b0;
    rxAt = st.decIdx;
    rxCode = 7'h00;
    satWord = sfp_sat16(decSampleIn);

    // encoder input: upper 13 bits carry the sample, low pad ignored
    if (link.encInValid && st.encInReady)
    begin
      next_st.encSample = link.encInData[15:3];
      next_st.encSampleValid = 1'b1;
      next_st.encSampleFirst = (st.encSampleCnt == 8'h00);
      next_st.encSampleCnt = (st.encSampleCnt == LAST_SAMPLE) ?
                             8'h00 : 8'(st.encSampleCnt + 8'h01);
    end

    ////////////////////////////////////////////////////////////////////////////
    // encoder output: format by word position, then two-entry buffer
    // the buffer absorbs a one-word stall without dropping the core's word
    push = paramValid && st.paramReady;
    pop = st.encOutValid && link.encOutReady;
    if (pop)
      next_st.rdPtr = ~st.rdPtr;
    if (push)
    begin
      next_st.fifo[st.wrPtr] = {st.encState == FRM_IDLE,
                                sfp_right_justify(paramCode,
                                                  st.encIdx)};
      next_st.wrPtr = ~st.wrPtr;
      next_st.encIdx = sfp_next_idx(st.encIdx);
      case (st.encState)
        FRM_IDLE: next_st.encState = FRM_RUN;
        FRM_RUN: next_st.encState = (st.encIdx == LAST_WORD) ? FRM_IDLE : FRM_RUN;
        default: next_st.encState = FRM_IDLE;
      endcase
    end
    next_st.count = 2'(st.count + {1'b0, push} - {1'b0, pop});
    next_st.paramReady = (next_st.count != 2'h2);
    next_st.encOutValid = (next_st.count != 2'h0);
    {next_st.encOutFirst, next_st.encOutData} = next_st.fifo[next_st.rdPtr];

    ////////////////////////////////////////////////////////////////////////////
    // decoder input: a frame start resynchronises the word position
    if (link.decInValid && st.decInReady)
    begin
      if (link.decInFirst)
        rxAt = FIRST_WORD;
      rxCode = sfp_mask_code(link.decInData[6:0],
                             rxAt);
      next_st.decCode = rxCode;
      next_st.decCodeIdx = rxAt;
      next_st.decCodeValid = 1'b1;
      next_st.decFrameStart = link.decInFirst;
      next_st.decIdx = sfp_next_idx(rxAt);
      if (sfp_is_lag(rxAt))
      begin
        // clamping keeps the history index inside the buffer for any code
        if (rxCode < LAG_MIN)
          next_st.decodedLag = LAG_MIN;
        else if (rxCode > LAG_MAX)
          next_st.decodedLag = LAG_MAX;
        else
          next_st.decodedLag = rxCode;
        next_st.lagOutOfRange = (rxCode < LAG_MIN) || (rxCode > LAG_MAX);
        next_st.decLagValid = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoder output: saturate, keep 13 bits, pad low bits with zero
    if (st.decOutValid && link.decOutReady)
      next_st.decOutValid = 1'b0;
    if (decSampleInValid && st.decSampleReady)
    begin
      next_st.decOutData = {satWord[15:3], PAD_BITS};
      next_st.decOutValid = 1'b1;
      next_st.decSampleSat = (satWord != decSampleIn[15:0]) ||
                             (decSampleIn[17:15] != {3{decSampleIn[15]}});
    end
    next_st.decSampleReady = !next_st.decOutValid;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.encInReady <= 1'b1;
      st.paramReady <= 1'b1;
      st.decInReady <= 1'b1;
      st.decSampleReady <= 1'b1;
    end
    else if (clkEn)
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.encInReady = st.encInReady;
  assign link.encOutValid = st.encOutValid;
  assign link.encOutData = st.encOutData;
  assign link.encOutFirst = st.encOutFirst;
  assign link.decInReady = st.decInReady;
  assign link.decOutValid = st.decOutValid;
  assign link.decOutData = st.decOutData;
  assign encSample = st.encSample;
  assign encSampleValid = st.encSampleValid;
  assign encSampleFirst = st.encSampleFirst;
  assign paramReady = st.paramReady;
  assign decCode = st.decCode;
  assign decCodeIdx = st.decCodeIdx;
  assign decCodeValid = st.decCodeValid;
  assign decFrameStart = st.decFrameStart;
  assign decodedLag = st.decodedLag;
  assign decLagValid = st.decLagValid;
  assign lagOutOfRange = st.lagOutOfRange;
  assign decSampleReady = st.decSampleReady;
  assign decSampleSat = st.decSampleSat;

endmodule

// ### design/sfp_pkg.sv
package sfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // word and frame layout
  localparam int WORD_W = 16;
  localparam int SAMPLE_W = 13;
  localparam int CODE_W = 7;
  localparam int FRAME_WORDS = 76;
  localparam int LAR_COUNT = 8;
  localparam int SUB_WORDS = 17;
  localparam logic [6:0] FIRST_WORD = 7'h00;
  localparam logic [6:0] LAST_WORD = 7'(FRAME_WORDS - 1);
  localparam logic [6:0] SUB_BASE = 7'(LAR_COUNT);
  localparam logic [6:0] SUB_LAG = 7'h00;
  localparam logic [6:0] SUB_GAIN = 7'h01;
  localparam logic [6:0] SUB_GRID = 7'h02;
  localparam logic [6:0] SUB_AMPL = 7'h03;
  localparam logic [2:0] PAD_BITS = 3'h0;

  // field widths in bits
  localparam logic [2:0] W_LAR12 = 3'h6;
  localparam logic [2:0] W_LAR34 = 3'h5;
  localparam logic [2:0] W_LAR56 = 3'h4;
  localparam logic [2:0] W_LAR78 = 3'h3;
  localparam logic [2:0] W_LAG = 3'h7;
  localparam logic [2:0] W_GAIN = 3'h2;
  localparam logic [2:0] W_GRID = 3'h2;
  localparam logic [2:0] W_AMPL = 3'h6;
  localparam logic [2:0] W_PULSE = 3'h3;

  // lag range under error-free transmission
  localparam logic [6:0] LAG_MIN = 7'h28;
  localparam logic [6:0] LAG_MAX = 7'h78;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int FRAME_MS = 20;
  localparam int SAMPLE_HZ = 8000;
  localparam int TICK_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
  localparam int FRAME_SAMPLES = SAMPLE_HZ * FRAME_MS / 1000;
  localparam logic [7:0] LAST_SAMPLE = 8'(FRAME_SAMPLES - 1);

  localparam logic signed [17:0] SAT_HI = 18'sh07FFF;
  localparam logic signed [17:0] SAT_LO = -18'sh08000;

  typedef enum logic [1:0] {FRM_IDLE = 2'h0, FRM_RUN = 2'h1} sfp_frame_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [6:0] sfp_sub_pos(input logic [6:0] idx);
    return 7'((idx - SUB_BASE) % 7'(SUB_WORDS));
  endfunction

  function automatic logic [2:0] sfp_field_width(input logic [6:0] idx);
    logic [2:0] w;
    w = W_PULSE;
    if (idx < SUB_BASE)
    begin
      case (idx[2:1])
        2'h0: w = W_LAR12;
        2'h1: w = W_LAR34;
        2'h2: w = W_LAR56;
        default: w = W_LAR78;
      endcase
    end
    else
    begin
      case (sfp_sub_pos(idx))
        SUB_LAG: w = W_LAG;
        SUB_GAIN: w = W_GAIN;
        SUB_GRID: w = W_GRID;
        SUB_AMPL: w = W_AMPL;
        default: w = W_PULSE;
      endcase
    end
    return w;
  endfunction

  function automatic logic [6:0] sfp_mask_code(input logic [6:0] code, input logic [6:0] idx);
    return code & (7'h7F >> (W_LAG - sfp_field_width(idx)));
  endfunction

  function automatic logic [15:0] sfp_right_justify(input logic [6:0] code,
                                                    input logic [6:0] idx);
    return {9'h000, sfp_mask_code(code, idx)};
  endfunction

  function automatic logic [15:0] sfp_left_justify(input logic [12:0] s);
    return {s, PAD_BITS};
  endfunction

  function automatic logic sfp_is_lag(input logic [6:0] idx);
    return (idx >= SUB_BASE) && (sfp_sub_pos(idx) == SUB_LAG);
  endfunction

  function automatic logic [6:0] sfp_next_idx(input logic [6:0] idx);
    return (idx == LAST_WORD) ? FIRST_WORD : 7'(idx + 7'h01);
  endfunction

  function automatic logic [15:0] sfp_sat16(input logic signed [17:0] v);
    if (v > SAT_HI)
      return 16'h7FFF;
    else if (v < SAT_LO)
      return 16'h8000;
    return v[15:0];
  endfunction

endpackage

// ### design/sfp_link_if.sv
`timescale 1ns/10ps
interface sfp_link_if;
  // encoder input samples, test end to codec end
  logic encInValid;
  logic encInReady;
  logic [15:0] encInData;
  // encoder output parameters, codec end to test end
  logic encOutValid;
  logic encOutReady;
  logic [15:0] encOutData;
  logic encOutFirst;
  // decoder input parameters, test end to codec end
  logic decInValid;
  logic decInReady;
  logic [15:0] decInData;
  logic decInFirst;
  // decoder output samples, codec end to test end
  logic decOutValid;
  logic decOutReady;
  logic [15:0] decOutData;

  modport dev (
    input encInValid, encInData, encOutReady, decInValid, decInData, decInFirst, decOutReady,
    output encInReady, encOutValid, encOutData, encOutFirst, decInReady, decOutValid,
    output decOutData
  );
  modport host (
    output encInValid, encInData, encOutReady, decInValid, decInData, decInFirst, decOutReady,
    input encInReady, encOutValid, encOutData, encOutFirst, decInReady, decOutValid,
    input decOutData
  );
endinterface

// ### design/sfp_test_end.sv
`timescale 1ns/10ps
module sfp_test_end
  import sfp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // link
  sfp_link_if.host link,
  // samples toward the encoder
  input wire logic [12:0] hostSample,
  input wire logic hostSampleValid,
  output logic hostSampleReady,
  output logic sampleMissed,
  // parameters toward the decoder
  input wire logic [6:0] hostCode,
  input wire logic hostCodeValid,
  output logic hostCodeReady,
  // parameters from the encoder
  input wire logic encCodeStall,
  output logic [6:0] encCode,
  output logic [6:0] encCodeIdx,
  output logic encCodeValid,
  output logic encFrameStart,
  // samples from the decoder
  output logic [12:0] decSample,
  output logic decSampleValid,
  output logic decSampleFirst,
  output logic padError
);
  import sfp_pkg::*;

  typedef struct packed {
    logic [11:0] tick;
    logic [12:0] hold;
    logic holdFull;
    logic sampleReady;
    logic missed;
    logic encInValid;
    logic [15:0] encInData;
    sfp_frame_t decState;
    logic [6:0] decIdx;
    logic [1:0][16:0] fifo;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
    logic codeReady;
    logic decInValid;
    logic [15:0] decInData;
    logic decInFirst;
    logic encOutReady;
    logic [6:0] rxIdx;
    logic [6:0] encCode;
    logic [6:0] encCodeIdx;
    logic encCodeValid;
    logic encFrameStart;
    logic [7:0] outCnt;
    logic [12:0] decSample;
    logic decSampleValid;
    logic decSampleFirst;
    logic padError;
  } sfp_host_t;

  sfp_host_t st;
  sfp_host_t next_st;
  logic push;
  logic pop;
  logic [6:0] rxAt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.missed = 1'b0;
    next_st.encCodeValid = 1'b0;
    next_st.encFrameStart = 1'b0;
    next_st.decSampleValid = 1'b0;
    next_st.decSampleFirst = 1'b0;
    next_st.padError = 1'b0;
    rxAt = st.rxIdx;

    // paced sample stream, one word per sample period
    next_st.tick = (st.tick == TICK_LAST) ? 12'h000 : 12'(st.tick + 12'h001);
    if (st.encInValid && link.encInReady)
      next_st.encInValid = 1'b0;
    if (hostSampleValid && st.sampleReady)
    begin
      next_st.hold = hostSample;
      next_st.holdFull = 1'b1;
    end
    if (st.tick == TICK_LAST)
    begin
      if (st.holdFull && !next_st.encInValid)
      begin
        next_st.encInData = sfp_left_justify(st.hold);
        next_st.encInValid = 1'b1;
        next_st.holdFull = (hostSampleValid && st.sampleReady);
      end
      else
        next_st.missed = 1'b1;
    end
    next_st.sampleReady = !next_st.holdFull;

    // parameter frames toward the decoder, through the two-entry buffer
    push = hostCodeValid && st.codeReady;
    pop = st.decInValid && link.decInReady;
    if (pop)
      next_st.rdPtr = ~st.rdPtr;
    if (push)
    begin
      next_st.fifo[st.wrPtr] = {st.decState == FRM_IDLE,
                                sfp_right_justify(hostCode,
                                                  st.decIdx)};
      next_st.wrPtr = ~st.wrPtr;
      next_st.decIdx = sfp_next_idx(st.decIdx);
      next_st.decState = (st.decIdx == LAST_WORD) ? FRM_IDLE : FRM_RUN;
    end
    next_st.count = 2'(st.count + {1'b0, push} - {1'b0, pop});
    next_st.codeReady = (next_st.count != 2'h2);
    next_st.decInValid = (next_st.count != 2'h0);
    {next_st.decInFirst, next_st.decInData} = next_st.fifo[next_st.rdPtr];

    // parameter frames from the encoder
    next_st.encOutReady = !encCodeStall;
    if (link.encOutValid && st.encOutReady)
    begin
      if (link.encOutFirst)
        rxAt = FIRST_WORD;
      next_st.encCode = sfp_mask_code(link.encOutData[6:0], rxAt);
      next_st.encCodeIdx = rxAt;
      next_st.encCodeValid = 1'b1;
      next_st.encFrameStart = link.encOutFirst;
      next_st.rxIdx = sfp_next_idx(rxAt);
    end

    // samples from the decoder
    if (link.decOutValid)
    begin
      next_st.decSample = link.decOutData[15:3];
      next_st.decSampleValid = 1'b1;
      next_st.decSampleFirst = (st.outCnt == 8'h00);
      next_st.padError = (link.decOutData[2:0] != PAD_BITS);
      next_st.outCnt = (st.outCnt == LAST_SAMPLE) ? 8'h00 : 8'(st.outCnt + 8'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.sampleReady <= 1'b1;
      st.codeReady <= 1'b1;
      st.encOutReady <= 1'b1;
    end
    else if (clkEn)
      st <= next_st;
  end

  assign link.encInValid = st.encInValid;
  assign link.encInData = st.encInData;
  assign link.decInValid = st.decInValid;
  assign link.decInData = st.decInData;
  assign link.decInFirst = st.decInFirst;
  assign link.encOutReady = st.encOutReady;
  // never stalls the decoder output; samples must flow at the sample rate
  assign link.decOutReady = 1'b1;
  assign hostSampleReady = st.sampleReady;
  assign sampleMissed = st.missed;
  assign hostCodeReady = st.codeReady;
  assign encCode = st.encCode;
  assign encCodeIdx = st.encCodeIdx;
  assign encCodeValid = st.encCodeValid;
  assign encFrameStart = st.encFrameStart;
  assign decSample = st.decSample;
  assign decSampleValid = st.decSampleValid;
  assign decSampleFirst = st.decSampleFirst;
  assign padError = st.padError;

endmodule

// ### sim/sfp_link_asserts.sv
`timescale 1ns/10ps
module sfp_link_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sample words
  input wire logic encInValid,
  input wire logic encInReady,
  input wire logic [15:0] encInData,
  input wire logic decOutValid,
  input wire logic [15:0] decOutData,
  // parameter words
  input wire logic encOutValid,
  input wire logic encOutReady,
  input wire logic [15:0] encOutData,
  input wire logic encOutFirst,
  input wire logic decInValid,
  input wire logic decInReady,
  input wire logic [15:0] decInData,
  input wire logic decInFirst
);
  logic [6:0] encCnt;
  logic [6:0] decCnt;
  logic [6:0] encPos;
  logic [6:0] decPos;
  logic [11:0] encGap;

  function automatic int fieldWidth(input logic [6:0] p);
    int s;
    s = (int'(p) - 8) % 17;
    return p < 7'h08 ? 6 - int'(p) / 2 : s == 0 ? 7 : s < 3 ? 2 : s == 3 ? 6 : 3;
  endfunction

  assign encPos = encOutFirst ? 7'h00 : encCnt;
  assign decPos = decInFirst ? 7'h00 : decCnt;

  ////////////////////////////////////////
  // 76 at reset, so the first word must open a frame
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      encCnt <= 7'h4C;
      decCnt <= 7'h4C;
      encGap <= 12'hFFF;
    end
    else
    begin
      if (encOutValid && encOutReady)
        encCnt <= encPos + 7'h01;
      if (decInValid && decInReady)
        decCnt <= decPos + 7'h01;
      if (encInValid && encInReady)
        encGap <= 12'h000;
      else if (encGap != 12'hFFF)
        encGap <= encGap + 12'h001;
    end
  end

  ////////////////////////////////////////
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_enc_sample_pad: assert property (encInValid |-> encInData[2:0] == 3'h0)
    else $error("encoder sample word has low bits set");
  a_dec_sample_pad: assert property (decOutValid |-> decOutData[2:0] == 3'h0)
    else $error("decoder sample word has low bits set");
  a_dec_sample_pace: assert property (decOutValid |=> !decOutValid)
    else $error("decoder samples closer than two cycles");
  a_enc_sample_rate: assert property (encInValid && encInReady |-> encGap >= 12'h9C3)
    else $error("encoder samples faster than the sample tick");
  a_enc_word_hold: assert property (encOutValid && !encOutReady |=>
    encOutValid && $stable(encOutData) && $stable(encOutFirst))
    else $error("parameter word changed while stalled");
  a_enc_field_width: assert property (
    encOutValid |-> (encOutData >> fieldWidth(encPos)) == 16'h0000)
    else $error("encoder parameter wider than its field");
  a_dec_field_width: assert property (
    decInValid |-> (decInData >> fieldWidth(decPos)) == 16'h0000)
    else $error("decoder parameter wider than its field");
  a_enc_frame_len: assert property (
    encOutValid && encOutReady |-> encOutFirst == (encCnt == 7'h4C))
    else $error("encoder frame start not every 76 words");
  a_dec_frame_len: assert property (
    decInValid && decInReady |-> decInFirst == (decCnt == 7'h4C))
    else $error("decoder frame start not every 76 words");
endmodule

// ### sim/speech_param_frame_format_tb_top.sv
`timescale 1ns/10ps
module speech_param_frame_format_tb_top;
  import sfp_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [12:0] hostSample = 13'h0000;
  logic hostSampleValid = 1'b0;
  logic [6:0] hostCode = 7'h00;
  logic hostCodeValid = 1'b0;
  logic encCodeStall = 1'b0;
  logic [6:0] paramCode = 7'h00;
  logic paramValid = 1'b0;
  logic signed [17:0] decSampleIn = 18'sh00000;
  logic decSampleInValid = 1'b0;
  logic hostSampleReady, hostCodeReady, encCodeValid, encFrameStart, decSampleValid, padError;
  logic [6:0] encCode, encCodeIdx, decCode, decCodeIdx, decodedLag;
  logic [12:0] decSample, encSample;
  logic encSampleValid, encSampleFirst, paramReady, decCodeValid, decFrameStart;
  logic decLagValid, lagOutOfRange, decSampleReady;
  logic sampleMissed, decSampleFirst, decSampleSat;
  logic satSeen = 1'b0;
  logic [3:0] ready;
  logic [31:0] expQ [4][$];
  logic [31:0] rnd = 32'h68F94215;
  logic [6:0] lagTab [8] = '{7'h00, 7'h27, 7'h28, 7'h29, 7'h77, 7'h78, 7'h79, 7'h7F};
  logic [17:0] smpTab [8] = '{18'h1FFFF, 18'h08000, 18'h07FFF, 18'h38000,
                              18'h37FFF, 18'h20000, 18'h00008, 18'h3FFF8};
  int fails = 0;
  int checkCount = 0;
  int cyc = 0;

  assign ready = {hostSampleReady, decSampleReady, hostCodeReady, paramReady};
  always #25 clk = ~clk;

  sfp_link_if sfp_link_if_i ();
  sfp_test_end sfp_test_end_i (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .link(sfp_link_if_i),
    .hostSample(hostSample), .hostSampleValid(hostSampleValid),
    .hostSampleReady(hostSampleReady), .sampleMissed(sampleMissed), .hostCode(hostCode),
    .hostCodeValid(hostCodeValid), .hostCodeReady(hostCodeReady), .encCodeStall(encCodeStall),
    .encCode(encCode), .encCodeIdx(encCodeIdx), .encCodeValid(encCodeValid),
    .encFrameStart(encFrameStart), .decSample(decSample), .decSampleValid(decSampleValid),
    .decSampleFirst(decSampleFirst), .padError(padError)
  );
  sfp_codec_end sfp_codec_end_i (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .link(sfp_link_if_i),
    .encSample(encSample), .encSampleValid(encSampleValid), .encSampleFirst(encSampleFirst),
    .paramCode(paramCode), .paramValid(paramValid), .paramReady(paramReady),
    .decCode(decCode), .decCodeIdx(decCodeIdx), .decCodeValid(decCodeValid),
    .decFrameStart(decFrameStart), .decodedLag(decodedLag), .decLagValid(decLagValid),
    .lagOutOfRange(lagOutOfRange), .decSampleIn(decSampleIn),
    .decSampleInValid(decSampleInValid), .decSampleReady(decSampleReady),
    .decSampleSat(decSampleSat)
  );
  sfp_link_asserts sfp_link_asserts_i (
    .clk(clk), .arst_n(arst_n),
    .encInValid(sfp_link_if_i.encInValid), .encInReady(sfp_link_if_i.encInReady),
    .encInData(sfp_link_if_i.encInData), .decOutValid(sfp_link_if_i.decOutValid),
    .decOutData(sfp_link_if_i.decOutData), .encOutValid(sfp_link_if_i.encOutValid),
    .encOutReady(sfp_link_if_i.encOutReady), .encOutData(sfp_link_if_i.encOutData),
    .encOutFirst(sfp_link_if_i.encOutFirst), .decInValid(sfp_link_if_i.decInValid),
    .decInReady(sfp_link_if_i.decInReady), .decInData(sfp_link_if_i.decInData),
    .decInFirst(sfp_link_if_i.decInFirst)
  );

  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  function automatic logic [6:0] fieldMask(input int p);
    int s;
    int w;
    s = (p - 8) % 17;
    w = p < 8 ? 6 - p / 2 : s == 0 ? 7 : s < 3 ? 2 : s == 3 ? 6 : 3;
    return 7'((1 << w) - 1);
  endfunction

  // an unexpected result finds no note and can never match
  function automatic logic [31:0] pop(input int k);
    return expQ[k].size() > 0 ? expQ[k].pop_front() : 32'hFFFFFFFF;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // valid held until ready is seen at an edge
  task automatic send(input int p, input logic [17:0] v);
    case (p)
      0: {paramValid, paramCode} <= {1'b1, v[6:0]};
      1: {hostCodeValid, hostCode} <= {1'b1, v[6:0]};
      2: {decSampleInValid, decSampleIn} <= {1'b1, v};
      default: {hostSampleValid, hostSample} <= {1'b1, v[12:0]};
    endcase
    do
      @(posedge clk);
    while (ready[p] !== 1'b1);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////
  always @(posedge clk)
  begin
    if (encCodeValid === 1'b1)
      check({17'h00000, encFrameStart, encCodeIdx, encCode}, pop(0));
    if (decCodeValid === 1'b1)
      check({8'h00, decLagValid, lagOutOfRange, decLagValid ? decodedLag : 7'h00,
        decFrameStart, decCodeIdx, decCode}, pop(1));
    if (decSampleValid === 1'b1)
      check({16'h0000, satSeen, decSampleFirst, padError, decSample}, pop(2));
    if (encSampleValid === 1'b1)
      check({18'h00000, encSampleFirst, encSample}, pop(3));
    // the hold register is kept supplied, so no tick may go empty
    if (arst_n && sampleMissed !== 1'b0)
      check({31'h00000000, sampleMissed}, 32'h00000000);
    // saturation flag leads the test end's sample pulse by one cycle
    satSeen <= decSampleSat;
    // random stalls force the two-entry buffer to fill
    encCodeStall <= (xs() & 32'h3) == 32'h0;
    cyc++;
    if (cyc == 12000)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    fork
      begin
        for (int i = 0; i < 80; i++)
        begin
          logic [31:0] rv;
          rv = xs();
          expQ[0].push_back({17'h00000, i % 76 == 0, 7'(i % 76), rv[6:0] & fieldMask(i % 76)});
          send(0, {11'h000, rv[6:0]});
        end
        paramValid <= 1'b0;
        $display("encoder parameter test done");
      end
      begin
        for (int i = 0; i < 152; i++)
        begin
          logic [31:0] rv;
          logic lag;
          int k;
          k = i % 76;
          rv = xs();
          lag = k >= 8 && (k - 8) % 17 == 0;
          if (lag)
            rv[6:0] = lagTab[(i / 76) * 4 + (k - 8) / 17];
          expQ[1].push_back({8'h00, lag, lag && (rv[6:0] < LAG_MIN || rv[6:0] > LAG_MAX),
            lag ? (rv[6:0] < LAG_MIN ? LAG_MIN : rv[6:0] > LAG_MAX ? LAG_MAX : rv[6:0]) : 7'h00,
            k == 0, 7'(k), rv[6:0] & fieldMask(k)});
          send(1, {11'h000, rv[6:0]});
        end
        hostCodeValid <= 1'b0;
        $display("decoder parameter test done");
      end
      begin
        for (int i = 0; i < 12; i++)
        begin
          logic [31:0] rv;
          logic signed [17:0] v;
          logic [15:0] e;
          rv = xs();
          v = i < 8 ? smpTab[i] : {{2{rv[15]}}, rv[15:0]};
          e = v > 18'sh07FFF ? 16'h7FFF : v < -18'sh08000 ? 16'h8000 : v[15:0];
          expQ[2].push_back({16'h0000, (v > 18'sh07FFF || v < -18'sh08000), i == 0, 1'b0,
            e[15:3]});
          send(2, v);
        end
        decSampleInValid <= 1'b0;
        $display("decoder sample test done");
      end
      begin
        for (int i = 0; i < 3; i++)
        begin
          logic [31:0] rv;
          rv = xs();
          expQ[3].push_back({18'h00000, i == 0, rv[12:0]});
          send(3, {5'h00, rv[12:0]});
        end
        hostSampleValid <= 1'b0;
        $display("encoder sample test done");
      end
    join
    for (int n = 0; n < 3000 && expQ[0].size() + expQ[1].size() + expQ[2].size()
         + expQ[3].size() > 0; n++)
      @(posedge clk);
    // a result still owed when the wait runs out is a failure
    if (expQ[0].size() + expQ[1].size() + expQ[2].size() + expQ[3].size() > 0)
      fails++;
    finish_test();
  end
endmodule
